// ==== trig_io_pkg.sv ====
// constants and types shared by the trigger and sync output logic
// assumes a single 20 MHz core clock drives every register of the block
package trig_io_pkg;

   // ------------------------------------------------------------
   // clock and pulse timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int ECHO_PULSE_NS = 6000;
   // exact division; a longest time would round down here anyway
   localparam int ECHO_PULSE_CYCLES = ECHO_PULSE_NS / CLK_PERIOD_NS;
   localparam int ECHO_CNT_W = 7;
   localparam logic [ECHO_CNT_W-1:0] ECHO_CNT_LAST = ECHO_CNT_W'(ECHO_PULSE_CYCLES - 1);
   localparam logic [ECHO_CNT_W-1:0] ECHO_CNT_ZERO = 7'h00;

   // ------------------------------------------------------------
   // reset values and trigger source choice
   // ------------------------------------------------------------
   localparam logic OUT_RESET = 1'b0;
   localparam logic SYNC_RESET = 1'b1; // trigger lines idle high

   typedef enum logic [1:0] {
      TRIG_SRC_SINGLE,
      TRIG_SRC_DIFF,
      TRIG_SRC_EITHER
   } trig_src_type;

   typedef enum logic {
      ECHO_IDLE,
      ECHO_HIGH
   } echo_state_type;

endpackage

// ==== trig_event_if.sv ====
// carrier for one synchronised trigger line and its falling-edge event
// assumes source and sink share the core clock
`timescale 1ns/10ps
interface trig_event_if;
   logic level;
   logic fall;
   modport source (output level, output fall);
   modport sink (input level, input fall);
endinterface

// ==== trig_edge_sync.sv ====
// two-flop synchroniser with a falling-edge detector for one trigger line
// assumes the pin is asynchronous to i_clk and idles high
`timescale 1ns/10ps
module trig_edge_sync
   import trig_io_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // raw asynchronous line
   input wire logic i_pin,
   // synchronised level and edge event
   trig_event_if.source ev
);

   logic meta_r;
   logic sync_r;
   logic prev_r;
   logic fall_r;

   // ------------------------------------------------------------
   // synchroniser; meta_r feeds sync_r only
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_r <= SYNC_RESET;
         sync_r <= SYNC_RESET;
      end else begin
         meta_r <= i_pin;
         sync_r <= meta_r;
      end
   end

   // edge after synchronisation
   // one event per high-to-low step, rising steps ignored
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         prev_r <= SYNC_RESET;
         fall_r <= 1'b0;
      end else begin
         prev_r <= sync_r;
         fall_r <= prev_r & ~sync_r;
      end
   end

   assign ev.level = prev_r;
   assign ev.fall = fall_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_fall_single: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      fall_r |=> !fall_r) else $error("falling edge event lasted two cycles");
   a_fall_cause: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      fall_r |-> ($past(prev_r) && !$past(sync_r))) else $error("event without high-to-low step");

endmodule

// ==== camera_trigger_sync_io.sv ====
// trigger input handling, trigger echo pulse and sensor timing outputs
// assumes the sensor sequencer runs on i_clk and its timing inputs are
// already synchronous; trigger pins are asynchronous and idle high
`timescale 1ns/10ps

module camera_trigger_sync_io
   import trig_io_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // external trigger pins
   input wire logic i_trigger_in,
   input wire logic i_diff_trig_p,
   input wire logic i_diff_trig_n,
   // configuration from camera control
   input wire trig_src_type i_trig_src,
   input wire logic i_trig_armed,
   input wire logic i_overlap_mode,
   // sensor sequencer timing
   input wire logic i_sensor_exposing,
   input wire logic i_readout_frame,
   input wire logic i_readout_pixels,
   // exposure start to the sequencer
   output logic o_expose_start,
   // auxiliary outputs
   output logic o_strobe_out,
   output logic o_trigger_out,
   output logic o_line_valid_out,
   output logic o_frame_valid_out
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   trig_event_if single_ev ();
   trig_event_if diff_ev ();

   logic diff_level;
   logic trig_hit;
   echo_state_type echo_state_r;
   echo_state_type echo_state_nxt;
   logic [ECHO_CNT_W-1:0] echo_cnt_r;
   logic [ECHO_CNT_W-1:0] echo_cnt_nxt;
   logic expose_start_r;
   logic strobe_r;
   logic echo_out_r;
   logic line_valid_r;
   logic frame_valid_r;

   // source filter shared by both trigger paths
   function automatic logic src_allows(input trig_src_type src, input logic diff_path);
      logic ok;
      ok = 1'b0;
      unique case (src)
         TRIG_SRC_SINGLE: ok = !diff_path;
         TRIG_SRC_DIFF: ok = diff_path;
         TRIG_SRC_EITHER: ok = 1'b1;
         default: ok = 1'b0; // code 2'b11 is illegal
      endcase
      return ok;
   endfunction

   // ------------------------------------------------------------
   // trigger inputs
   // ------------------------------------------------------------
   // pair as one signal
   // receiver view: high when p above n; equal pins read as low
   assign diff_level = i_diff_trig_p & ~i_diff_trig_n;

   trig_edge_sync u_sync_single (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_pin(i_trigger_in),
      .ev(single_ev.source)
   );

   trig_edge_sync u_sync_diff (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_pin(diff_level),
      .ev(diff_ev.source)
   );

   // one event per edge
   // both paths in one cycle still count as one trigger
   assign trig_hit = i_trig_armed &
                     ((single_ev.fall & src_allows(i_trig_src, 1'b0)) |
                      (diff_ev.fall & src_allows(i_trig_src, 1'b1)));

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         expose_start_r <= OUT_RESET;
      end else begin
         expose_start_r <= trig_hit;
      end
   end

   // ------------------------------------------------------------
   // trigger echo pulse
   // ------------------------------------------------------------
   // fixed pulse length
   // a new trigger mid-pulse restarts the count so no event is lost
   always_comb begin
      echo_state_nxt = echo_state_r;
      echo_cnt_nxt = echo_cnt_r;
      unique case (echo_state_r)
         ECHO_IDLE: begin
            if (trig_hit) begin
               echo_state_nxt = ECHO_HIGH;
               echo_cnt_nxt = ECHO_CNT_ZERO;
            end
         end
         ECHO_HIGH: begin
            if (trig_hit) begin
               echo_cnt_nxt = ECHO_CNT_ZERO;
            end else if (echo_cnt_r == ECHO_CNT_LAST) begin
               echo_state_nxt = ECHO_IDLE;
            end else begin
               echo_cnt_nxt = echo_cnt_r + 7'h01;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         echo_state_r <= ECHO_IDLE;
         echo_cnt_r <= ECHO_CNT_ZERO;
      end else begin
         echo_state_r <= echo_state_nxt;
         echo_cnt_r <= echo_cnt_nxt;
      end
   end

   // echo starts with edge
   // registered from the next state so the pin rises with the start pulse
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         echo_out_r <= OUT_RESET;
      end else begin
         echo_out_r <= (echo_state_nxt == ECHO_HIGH);
      end
   end

   // ------------------------------------------------------------
   // sensor timing outputs
   // ------------------------------------------------------------
   // strobe during exposure
   // outside overlapped mode the strobe is held low
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         strobe_r <= OUT_RESET;
      end else begin
         strobe_r <= i_overlap_mode & i_sensor_exposing;
      end
   end

   // line valid gating
   // gated by frame so stray pixel flags in frame gaps stay hidden
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         line_valid_r <= OUT_RESET;
      end else begin
         line_valid_r <= i_readout_frame & i_readout_pixels;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         frame_valid_r <= OUT_RESET;
      end else begin
         frame_valid_r <= i_readout_frame;
      end
   end

   // every output straight from a flop
   assign o_expose_start = expose_start_r;
   assign o_strobe_out = strobe_r;
   assign o_trigger_out = echo_out_r;
   assign o_line_valid_out = line_valid_r;
   assign o_frame_valid_out = frame_valid_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   // helper: length of the current echo pulse since its last (re)start
   logic [ECHO_CNT_W:0] echo_len_r;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         echo_len_r <= 8'h00;
      end else if (expose_start_r) begin
         echo_len_r <= 8'h01;
      end else if (echo_out_r) begin
         echo_len_r <= echo_len_r + 8'h01;
      end else begin
         echo_len_r <= 8'h00;
      end
   end

   a_strobe_exposure: assert property (
      (i_overlap_mode && i_sensor_exposing) |=> o_strobe_out
   ) else $error("strobe low during overlapped exposure");
   a_strobe_idle: assert property (
      !(i_overlap_mode && i_sensor_exposing) |=> !o_strobe_out
   ) else $error("strobe high outside exposure");
   a_start_cause: assert property (
      o_expose_start |-> $past(trig_hit)
   ) else $error("exposure started without trigger edge");
   a_rise_no_start: assert property (
      ($rose(single_ev.level) && !diff_ev.fall) |=> !o_expose_start
   ) else $error("rising trigger started exposure");
   a_line_high: assert property (
      (i_readout_frame && i_readout_pixels) |=> o_line_valid_out
   ) else $error("line valid low during pixels");
   a_line_gap_low: assert property (
      !(i_readout_frame && i_readout_pixels) |=> !o_line_valid_out
   ) else $error("line valid high in a gap");
   a_echo_hold: assert property (
      o_expose_start |-> o_trigger_out [*8]
   ) else $error("echo pulse ended early");
   a_echo_length: assert property (
      // the helper already holds the full length in the cycle the pin reads low
      $fell(o_trigger_out) |-> (echo_len_r == 8'(ECHO_PULSE_CYCLES))
   ) else $error("echo pulse length wrong");
   a_echo_start: assert property (
      trig_hit |=> (o_trigger_out && o_expose_start)
   ) else $error("echo did not start with trigger");
   a_diff_start: assert property (
      // the unused source code accepts nothing, so only the two selecting codes count
      (diff_ev.fall && i_trig_armed &&
       (i_trig_src == TRIG_SRC_DIFF || i_trig_src == TRIG_SRC_EITHER)) |=> o_expose_start
   ) else $error("differential edge ignored");
   a_frame_level: assert property (
      i_readout_frame |=> o_frame_valid_out
   ) else $error("frame valid wrong");
   a_frame_gap: assert property (
      !i_readout_frame |=> (!o_frame_valid_out && !o_line_valid_out)
   ) else $error("frame valid high between frames");

   c_single_trigger: cover property (single_ev.fall && trig_hit);
   c_diff_trigger: cover property (diff_ev.fall && trig_hit);
   c_echo_restart: cover property (trig_hit && echo_state_r == ECHO_HIGH);
   c_full_echo: cover property ($fell(o_trigger_out));
   c_line_in_frame: cover property ($rose(o_line_valid_out) && o_frame_valid_out);

endmodule

// ==== trig_source_model.sv ====
// stand-in for the external trigger source driving the camera
// assumes fire requests are set by the bench at the falling clock edge
`timescale 1ns/10ps
module trig_source_model (
   // clock
   input wire logic i_clk,
   // fire requests from the bench
   input wire logic i_fire_single,
   input wire logic i_fire_diff,
   // trigger lines toward the camera
   output logic o_trigger_in,
   output logic o_diff_p,
   output logic o_diff_n
);
   logic [2:0] low_single_r = 3'h0;
   logic [2:0] low_diff_r = 3'h0;
   // ------------------------------------------------------------
   // low pulse timing
   // ------------------------------------------------------------
   // idle high, four cycles low, then high again
   always @(posedge i_clk) begin
      if (i_fire_single) begin
         low_single_r <= 3'h4;
      end else if (low_single_r != 3'h0) begin
         low_single_r <= low_single_r - 3'h1;
      end
      if (i_fire_diff) begin
         low_diff_r <= 3'h4;
      end else if (low_diff_r != 3'h0) begin
         low_diff_r <= low_diff_r - 3'h1;
      end
   end
   // pair always driven opposite, so it never reads as equal pins
   assign o_trigger_in = (low_single_r == 3'h0);
   assign o_diff_p = (low_diff_r == 3'h0);
   assign o_diff_n = (low_diff_r != 3'h0);
endmodule

// ==== camera_trigger_sync_io_tb_top.sv ====
// self-checking bench for the trigger and sync output block
// assumes the source model owns the trigger pins; the bench drives the rest
`timescale 1ns/10ps
module camera_trigger_sync_io_tb_top;
   import trig_io_pkg::*;
   logic i_clk = 1'b0;
   logic i_reset_n = 1'b0;
   logic fire_s = 1'b0;
   logic fire_d = 1'b0;
   logic pin;
   logic dp;
   logic dn;
   trig_src_type src = TRIG_SRC_SINGLE;
   logic armed = 1'b0;
   logic [3:0] tim = 4'h0;
   logic start;
   logic strobe;
   logic echo;
   logic line_v;
   logic frame_v;
   int n_fail = 0;
   int check_count = 0;
   int cycles = 0;

   always #25 i_clk = ~i_clk;

   trig_source_model i_src (.i_clk(i_clk), .i_fire_single(fire_s), .i_fire_diff(fire_d),
      .o_trigger_in(pin), .o_diff_p(dp), .o_diff_n(dn));

   camera_trigger_sync_io i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_trigger_in(pin),
      .i_diff_trig_p(dp), .i_diff_trig_n(dn), .i_trig_src(src), .i_trig_armed(armed),
      .i_overlap_mode(tim[3]), .i_sensor_exposing(tim[2]), .i_readout_frame(tim[1]),
      .i_readout_pixels(tim[0]), .o_expose_start(start), .o_strobe_out(strobe),
      .o_trigger_out(echo), .o_line_valid_out(line_v), .o_frame_valid_out(frame_v));

   // ------------------------------------------------------------
   // reporting
   // ------------------------------------------------------------
   task automatic wrap_up;
      if (n_fail == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic expect_eq(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: %s got %0d want %0d", $time, what, got, exp);
      end
   endtask

   // a hung run still ends in the verdict
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         wrap_up();
      end
   end

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // fire one or both lines, then count starts and echo cycles
   task automatic run_trig(input logic [1:0] which, input trig_src_type s, input logic arm,
      input int exp_n);
      int n_start;
      int n_echo;
      int first;
      logic echo_at_start;
      n_start = 0;
      n_echo = 0;
      first = -1;
      echo_at_start = 1'b0;
      @(negedge i_clk);
      src = s;
      armed = arm;
      fire_s = which[0];
      fire_d = which[1];
      for (int i = 1; i <= 160; i++) begin
         @(negedge i_clk);
         fire_s = 1'b0;
         fire_d = 1'b0;
         if (start === 1'b1) begin
            n_start++;
            if (first < 0) begin
               first = i;
               echo_at_start = echo;
            end
         end
         if (echo === 1'b1) begin
            n_echo++;
         end
      end
      expect_eq(8'(n_start), 8'(exp_n), "start count");
      expect_eq(8'(n_echo), 8'(exp_n * ECHO_PULSE_CYCLES), "echo cycles");
      if (exp_n > 0) begin
         expect_eq(8'(first >= 4 && first <= 6), 8'h01, "start latency");
         expect_eq(8'(echo_at_start), 8'h01, "echo with start");
      end
   endtask

   // second edge 40 cycles after the first: two starts, echo stretched to 40 + full length
   task automatic run_retrig;
      int n_start;
      int n_echo;
      n_start = 0;
      n_echo = 0;
      @(negedge i_clk);
      src = TRIG_SRC_SINGLE;
      armed = 1'b1;
      fire_s = 1'b1;
      for (int i = 1; i <= 220; i++) begin
         @(negedge i_clk);
         fire_s = (i == 40);
         if (start === 1'b1) begin
            n_start++;
         end
         if (echo === 1'b1) begin
            n_echo++;
         end
      end
      expect_eq(8'(n_start), 8'h02, "retrigger starts");
      expect_eq(8'(n_echo), 8'(40 + ECHO_PULSE_CYCLES), "retrigger echo");
   endtask

   // every combination of sequencer timing levels, two cycles each
   task automatic run_timing;
      for (int v = 0; v < 16; v++) begin
         @(negedge i_clk);
         tim = 4'(v);
         @(negedge i_clk);
         expect_eq(8'(strobe), 8'(tim[3] & tim[2]), "strobe");
         expect_eq(8'(line_v), 8'(tim[1] & tim[0]), "line valid");
         expect_eq(8'(frame_v), 8'(tim[1]), "frame valid");
      end
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (3) @(negedge i_clk);
      expect_eq(8'(echo | start | strobe | line_v | frame_v), 8'h00, "outputs in reset");
      i_reset_n = 1'b1;
      repeat (3) @(negedge i_clk);
      run_trig(2'b01, TRIG_SRC_SINGLE, 1'b1, 1);
      run_trig(2'b10, TRIG_SRC_DIFF, 1'b1, 1);
      run_trig(2'b01, TRIG_SRC_DIFF, 1'b1, 0);
      run_trig(2'b11, TRIG_SRC_EITHER, 1'b0, 0);
      run_trig(2'b11, TRIG_SRC_EITHER, 1'b1, 1);
      run_trig(2'b11, trig_src_type'(2'h3), 1'b1, 0);
      run_retrig();
      run_timing();
      wrap_up();
   end
endmodule
